// File: shared/llc_defs.vh
// register map, field layout, reset values and bus codes for the loop control slice
`ifndef LLC_DEFS_VH
`define LLC_DEFS_VH

// ----------------------------------------------------------------------
// register indexes (byte address = index * 4)
// ----------------------------------------------------------------------
`define LLC_IDX_MULT      16'hF000
`define LLC_IDX_PRESCALE  16'hF001
`define LLC_IDX_SOURCE    16'hF002
`define LLC_IDX_RUN       16'hF003
`define LLC_IDX_LOCK      16'hF004
`define LLC_IDX_AUX       16'hF005
`define LLC_IDX_IRQ_STAT  16'hF00E
`define LLC_IDX_IRQ_MASK  16'hF00F

// ----------------------------------------------------------------------
// decoded register selectors
// ----------------------------------------------------------------------
`define LLC_SEL_NONE      4'h0
`define LLC_SEL_MULT      4'h1
`define LLC_SEL_PRESCALE  4'h2
`define LLC_SEL_SOURCE    4'h3
`define LLC_SEL_RUN       4'h4
`define LLC_SEL_LOCK      4'h5
`define LLC_SEL_AUX       4'h6
`define LLC_SEL_IRQ_STAT  4'h7
`define LLC_SEL_IRQ_MASK  4'h8

// ----------------------------------------------------------------------
// field widths and reset values
// ----------------------------------------------------------------------
`define LLC_MULT_W        7
`define LLC_MULT_RST      7'h60
`define LLC_PRE_RST       2'h0
`define LLC_AUX_RST       3'h0
`define LLC_AUX_EN_BIT    0
`define LLC_AUX_RATE_LSB  1
`define LLC_IRQ_W         2
`define LLC_IRQ_GAIN_BIT  0
`define LLC_IRQ_LOSS_BIT  1

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define LLC_RESP_OKAY     2'h0
`define LLC_RESP_SLVERR   2'h2

`endif

// File: core/llc_loop_ctrl.v
// loop enable, lock flag and auxiliary clock output control with an AXI4-Lite slave
//
// Notes on behaviour
// - no lock acquisition while run request clear
// - run request clear keeps dependent clocks idle
// - settings applied only on run rising edge
// - lock flag read-only bit zero, rest zero
// - lock needs stable input, valid config, run
// - rate field doubles output per code step
// - code zero gives prescaled reference rate (code: ref_clk over 2*AUX_HALF, prescale not applied)
// - drive enable one drives pin, else tristated
// - run, lock, output config reset to zero
// - prescale divides master clock by 1,2,4,8
// - source bit: zero direct, one loop
// - seven-bit multiplier, reset value 0x60
`include "llc_defs.vh"
`default_nettype none

module llc_loop_ctrl #(
   parameter ADDR_W     = 18,
   parameter LOCK_TICKS = 64,
   parameter GAP_LIMIT  = 255,
   parameter AUX_HALF   = 16
) (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst,
   // write address channel
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   // write data channel
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // write response channel
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // read address channel
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   // read data channel
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // master clock, sampled as a synchronous level
   input  wire        master_clock_input_pin,
   // auxiliary clock pin, oe low while driving
   output reg         aux_clock_pin,
   output reg         aux_clock_oe_n,
   // loop state towards the clock generators
   output reg         loop_running,
   output reg         loop_locked,
   output reg         core_source_select,
   output reg  [6:0]  active_multiplier,
   output reg  [1:0]  active_prescale,
   // interrupt
   output reg         irq
);

   // ----------------------------------------------------------------------
   // address decode, shared by the read and write paths
   // ----------------------------------------------------------------------
   function [3:0] reg_sel;
      input [ADDR_W-1:0] addr;
      reg   [15:0]       idx;
      begin
         idx = addr[ADDR_W-1:2];
         if (addr[1:0] != 2'h0) reg_sel = `LLC_SEL_NONE;
         else case (idx)
            `LLC_IDX_MULT:     reg_sel = `LLC_SEL_MULT;
            `LLC_IDX_PRESCALE: reg_sel = `LLC_SEL_PRESCALE;
            `LLC_IDX_SOURCE:   reg_sel = `LLC_SEL_SOURCE;
            `LLC_IDX_RUN:      reg_sel = `LLC_SEL_RUN;
            `LLC_IDX_LOCK:     reg_sel = `LLC_SEL_LOCK;
            `LLC_IDX_AUX:      reg_sel = `LLC_SEL_AUX;
            `LLC_IDX_IRQ_STAT: reg_sel = `LLC_SEL_IRQ_STAT;
            `LLC_IDX_IRQ_MASK: reg_sel = `LLC_SEL_IRQ_MASK;
            default:           reg_sel = `LLC_SEL_NONE;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------------
   // staged (software-written) settings and held write request
   // ----------------------------------------------------------------------
   reg [6:0]              stage_mult;
   reg [1:0]              stage_pre;
   reg                    stage_src;
   reg [2:0]              stage_aux;
   reg                    run_req;
   reg [2:0]              active_aux;
   reg [`LLC_IRQ_W-1:0]   irq_stat;
   reg [`LLC_IRQ_W-1:0]   irq_mask;
   reg [ADDR_W-1:0]       wr_addr;
   reg [31:0]             wr_data;
   reg                    wr_strb0;
   reg                    aw_held;
   reg                    w_held;

   wire       aw_take = s_axi_awvalid & s_axi_awready;
   wire       w_take  = s_axi_wvalid & s_axi_wready;
   wire       ar_take = s_axi_arvalid & s_axi_arready;
   wire       wr_go   = aw_held & w_held & ~s_axi_bvalid;
   wire [3:0] wr_sel  = reg_sel(wr_addr);
   wire [3:0] rd_sel  = reg_sel(s_axi_araddr);
   // only the low byte lane carries defined bits
   wire       wr_en   = wr_go & wr_strb0;
   wire       run_rise = wr_en & (wr_sel == `LLC_SEL_RUN) & wr_data[0] & ~run_req;
   wire       run_fall = wr_en & (wr_sel == `LLC_SEL_RUN) & ~wr_data[0];

   // ----------------------------------------------------------------------
   // write channels: address and data taken in either order
   // ----------------------------------------------------------------------
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `LLC_RESP_OKAY;
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         wr_addr       <= {ADDR_W{1'b0}};
         wr_data       <= 32'h00000000;
         wr_strb0      <= 1'b0;
      end else begin
         if (aw_take) begin
            wr_addr       <= s_axi_awaddr;
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            wr_data      <= s_axi_wdata;
            wr_strb0     <= s_axi_wstrb[0];
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            // the lock flag is read-only, so a write to it is refused
            s_axi_bresp  <= (wr_sel == `LLC_SEL_NONE || wr_sel == `LLC_SEL_LOCK) ?
                            `LLC_RESP_SLVERR : `LLC_RESP_OKAY;
         end
         if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // register storage; run rising edge copies staged values to active
   // ----------------------------------------------------------------------
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         stage_mult         <= `LLC_MULT_RST;
         stage_pre          <= `LLC_PRE_RST;
         stage_src          <= 1'b0;
         stage_aux          <= `LLC_AUX_RST;
         run_req            <= 1'b0;
         irq_mask           <= {`LLC_IRQ_W{1'b0}};
         active_multiplier  <= `LLC_MULT_RST;
         active_prescale    <= `LLC_PRE_RST;
         core_source_select <= 1'b0;
         active_aux         <= `LLC_AUX_RST;
         loop_running       <= 1'b0;
      end else begin
         if (wr_en) begin
            case (wr_sel)
               `LLC_SEL_MULT:     stage_mult <= wr_data[`LLC_MULT_W-1:0];
               `LLC_SEL_PRESCALE: stage_pre  <= wr_data[1:0];
               `LLC_SEL_SOURCE:   stage_src  <= wr_data[0];
               `LLC_SEL_RUN:      run_req    <= wr_data[0];
               `LLC_SEL_AUX:      stage_aux  <= wr_data[2:0];
               `LLC_SEL_IRQ_MASK: irq_mask   <= wr_data[`LLC_IRQ_W-1:0];
               default:           irq_mask   <= irq_mask;
            endcase
         end
         // staged values only take effect here; earlier writes stay inert
         if (run_rise) begin
            active_multiplier  <= stage_mult;
            active_prescale    <= stage_pre;
            core_source_select <= stage_src;
            active_aux         <= stage_aux;
         end
         loop_running <= run_rise ? 1'b1 : (run_fall ? 1'b0 : loop_running);
      end
   end

   // ----------------------------------------------------------------------
   // input prescaler on master clock rising edges
   // ----------------------------------------------------------------------
   reg        mclk_q;
   reg  [2:0] pre_cnt;
   reg        loop_tick;
   wire       mclk_rise = master_clock_input_pin & ~mclk_q;
   // divide ratio 2^code: all-ones of the low bits marks a tick
   wire [2:0] pre_mask  = (3'h1 << active_prescale) - 3'h1;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mclk_q    <= 1'b0;
         pre_cnt   <= 3'h0;
         loop_tick <= 1'b0;
      end else begin
         mclk_q    <= master_clock_input_pin;
         loop_tick <= 1'b0;
         if (!loop_running) begin
            pre_cnt <= 3'h0;
         end else if (mclk_rise) begin
            pre_cnt   <= (pre_cnt & pre_mask) == pre_mask ? 3'h0 : pre_cnt + 3'h1;
            loop_tick <= (pre_cnt & pre_mask) == pre_mask;
         end
      end
   end

   // ----------------------------------------------------------------------
   // lock acquisition: enough ticks with no long gap, valid multiplier
   // ----------------------------------------------------------------------
   reg  [15:0] acq_cnt;
   reg  [15:0] gap_cnt;
   wire        cfg_ok    = active_multiplier != {`LLC_MULT_W{1'b0}};
   wire        gap_over  = gap_cnt >= GAP_LIMIT[15:0];
   wire        acquiring = loop_running & cfg_ok & ~gap_over;
   wire        next_lock = acquiring & (acq_cnt >= LOCK_TICKS[15:0]);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         acq_cnt     <= 16'h0000;
         gap_cnt     <= 16'h0000;
         loop_locked <= 1'b0;
      end else begin
         if (!loop_running) begin
            gap_cnt <= 16'h0000;
         end else if (loop_tick) begin
            gap_cnt <= 16'h0000;
         end else if (!gap_over) begin
            gap_cnt <= gap_cnt + 16'h0001;
         end
         // any loss of input or run restarts the settling count
         if (!acquiring) begin
            acq_cnt <= 16'h0000;
         end else if (loop_tick && acq_cnt < LOCK_TICKS[15:0]) begin
            acq_cnt <= acq_cnt + 16'h0001;
         end
         loop_locked <= next_lock;
      end
   end

   // ----------------------------------------------------------------------
   // auxiliary clock: base half period shortened by 2^rate
   // ----------------------------------------------------------------------
   reg  [15:0] aux_cnt;
   wire [1:0]  aux_rate  = active_aux[`LLC_AUX_RATE_LSB+1:`LLC_AUX_RATE_LSB];
   wire [15:0] aux_half0 = AUX_HALF[15:0] >> aux_rate;
   wire [15:0] aux_half  = (aux_half0 == 16'h0000) ? 16'h0001 : aux_half0;
   wire        aux_drive = active_aux[`LLC_AUX_EN_BIT];

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         aux_cnt        <= 16'h0000;
         aux_clock_pin  <= 1'b0;
         aux_clock_oe_n <= 1'b1;
      end else begin
         aux_clock_oe_n <= ~aux_drive;
         // the copy only runs from a locked loop; otherwise the pin idles low
         if (!loop_locked || !aux_drive) begin
            aux_cnt       <= 16'h0000;
            aux_clock_pin <= 1'b0;
         end else if (aux_cnt + 16'h0001 >= aux_half) begin
            aux_cnt       <= 16'h0000;
            aux_clock_pin <= ~aux_clock_pin;
         end else begin
            aux_cnt <= aux_cnt + 16'h0001;
         end
      end
   end

   // ----------------------------------------------------------------------
   // interrupt status: lock gained and lock lost, cleared by read
   // ----------------------------------------------------------------------
   wire [`LLC_IRQ_W-1:0] irq_evt = {loop_locked & ~next_lock, ~loop_locked & next_lock};
   wire                  stat_rd = ar_take & (rd_sel == `LLC_SEL_IRQ_STAT);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         irq_stat <= {`LLC_IRQ_W{1'b0}};
         irq      <= 1'b0;
      end else begin
         // a new event in the clearing cycle survives
         irq_stat <= (stat_rd ? {`LLC_IRQ_W{1'b0}} : irq_stat) | irq_evt;
         irq      <= |(((stat_rd ? {`LLC_IRQ_W{1'b0}} : irq_stat) | irq_evt) & irq_mask);
      end
   end

   // ----------------------------------------------------------------------
   // read channel: one-cycle answer, reserved bits read zero
   // ----------------------------------------------------------------------
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `LLC_RESP_OKAY;
      end else begin
         if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= (rd_sel == `LLC_SEL_NONE) ? `LLC_RESP_SLVERR : `LLC_RESP_OKAY;
            case (rd_sel)
               `LLC_SEL_MULT:     s_axi_rdata <= {25'h0, stage_mult};
               `LLC_SEL_PRESCALE: s_axi_rdata <= {30'h0, stage_pre};
               `LLC_SEL_SOURCE:   s_axi_rdata <= {31'h0, stage_src};
               `LLC_SEL_RUN:      s_axi_rdata <= {31'h0, run_req};
               `LLC_SEL_LOCK:     s_axi_rdata <= {31'h0, loop_locked};
               `LLC_SEL_AUX:      s_axi_rdata <= {29'h0, stage_aux};
               `LLC_SEL_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat};
               `LLC_SEL_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
               default:           s_axi_rdata <= 32'h00000000;
            endcase
         end
         if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// File: tb/llc_mclk_model.sv
// master clock source model driving the loop input pin
`default_nettype none
module llc_mclk_model #(
   parameter int HALF = 2
) (
   // clock and run request from the bench
   input  wire logic ref_clk,
   input  wire logic run_clock,
   // master clock towards the block
   output var  logic master_clock_input_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt;
   initial cnt = 0;
   initial master_clock_input_pin = 1'b0;
   // steady clock while running; parked low when stopped so the loop sees a real gap
   always @(posedge ref_clk) begin
      if (!run_clock) begin
         cnt <= 0;
         master_clock_input_pin <= 1'b0;
      end else if (cnt == HALF - 1) begin
         cnt <= 0;
         master_clock_input_pin <= !master_clock_input_pin;
      end else begin
         cnt <= cnt + 1;
      end
   end
endmodule
`default_nettype wire

// File: tb/llc_loop_ctrl_assertions.sv
// port-level checker for the loop control slice
`default_nettype none
module llc_loop_ctrl_assertions (
   // clock and reset
   input wire logic       ref_clk, rst,
   // register bus handshakes
   input wire logic       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
   input wire logic       s_axi_rvalid, s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic [31:0] s_axi_rdata,
   // loop and pin state
   input wire logic       loop_running, loop_locked, core_source_select,
   input wire logic [6:0] active_multiplier,
   input wire logic [1:0] active_prescale,
   input wire logic       aux_clock_pin, aux_clock_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_lock_needs_run: assert property (
      !loop_running && !$past(loop_running) |-> !loop_locked)
      else $error("lock flag high while loop stopped");
   a_aux_idle_low: assert property (
      !loop_locked |=> !aux_clock_pin)
      else $error("aux clock toggles without lock");
   a_cfg_only_rise: assert property (
      !$rose(loop_running) |-> $stable({active_multiplier, active_prescale,
                                        core_source_select}))
      else $error("active settings changed without run rise");
   // the pin enable is registered once more, so it follows the run rise by a cycle
   a_oe_after_rise: assert property (
      $changed(aux_clock_oe_n) |-> $past(loop_running) && !$past(loop_running, 2))
      else $error("pin enable changed without run rise");
   a_lock_rise_ok: assert property (
      $rose(loop_locked) |-> loop_running && active_multiplier != 7'h00)
      else $error("lock gained without run or valid multiplier");
   a_rdata_upper: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
      else $error("reserved read bits not zero");
   a_read_answer: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   a_bresp_hold: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   a_rdata_hold: assert property (
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped before taken");
endmodule

bind llc_loop_ctrl llc_loop_ctrl_assertions llc_loop_ctrl_assertions_inst (
   .ref_clk(ref_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_bresp(s_axi_bresp), .s_axi_rdata(s_axi_rdata), .loop_running(loop_running),
   .loop_locked(loop_locked), .core_source_select(core_source_select),
   .active_multiplier(active_multiplier), .active_prescale(active_prescale),
   .aux_clock_pin(aux_clock_pin), .aux_clock_oe_n(aux_clock_oe_n));
`default_nettype wire

// File: tb/tb.sv
// self-checking bench for the loop control slice
`include "llc_defs.vh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, rst = 1'b1, mclk_run = 1'b0;
   logic [17:0] awaddr = 18'h00000, araddr = 18'h00000;
   logic [31:0] wdata = 32'h0, rdata, got;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, mclk, pin, oe_n, running, locked, src, irq;
   logic [1:0] bresp, rresp, pre;
   logic [6:0] mult;
   int err_count = 0, check_count = 0, n;

   always #12.5 ref_clk = ~ref_clk;

   // short lock count keeps each acquisition to a few dozen cycles
   llc_loop_ctrl #(.LOCK_TICKS(4)) llc_loop_ctrl_inst (
      .ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .master_clock_input_pin(mclk), .aux_clock_pin(pin), .aux_clock_oe_n(oe_n),
      .loop_running(running), .loop_locked(locked), .core_source_select(src),
      .active_multiplier(mult), .active_prescale(pre), .irq(irq));
   llc_mclk_model llc_mclk_model_inst (
      .ref_clk(ref_clk), .run_clock(mclk_run), .master_clock_input_pin(mclk));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one write; bready raised only once both channels are taken, in the same cycle bvalid rises, so bvalid never stalls
   task automatic wr(input logic [15:0] idx, input logic [31:0] d,
                     input logic [3:0] st = 4'hF, input logic [1:0] er = `LLC_RESP_OKAY);
      @(posedge ref_clk);
      awaddr <= {idx, 2'b00};
      wdata <= d;
      wstrb <= st;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (!awvalid && !wvalid) bready <= 1'b1;
      end while (!(bvalid === 1'b1 && bready));
      bready <= 1'b0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask
   // one read; a zero mask skips the data compare (used for polling)
   task automatic rd(input logic [15:0] idx, input logic [31:0] msk, input logic [31:0] e,
                     input logic [1:0] er = `LLC_RESP_OKAY);
      @(posedge ref_clk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready) arvalid <= 1'b0;
         if (!arvalid) rready <= 1'b1;
      end while (!(rvalid === 1'b1 && rready));
      rready <= 1'b0;
      got = rdata;
      if (msk != 32'h0) chk("rdata", e, rdata & msk);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
   endtask
   // lock time is not fixed, so software polls the flag
   task automatic wait_lock();
      got = 32'h0;
      for (int i = 0; i < 40 && got !== 32'h1; i++) rd(`LLC_IDX_LOCK, 32'h0, 32'h0);
      chk("lock", 32'h1, got);
   endtask
   task automatic count_rises(output int c);
      logic prev;
      c = 0;
      prev = pin;
      repeat (128) begin
         @(negedge ref_clk);
         if (pin && !prev) c++;
         prev = pin;
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      wrap_up();
   end

   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      // reset values, read-only lock and an unmapped place
      rd(`LLC_IDX_RUN, 32'hFFFFFFFF, 32'h0);
      rd(`LLC_IDX_AUX, 32'hFFFFFFFF, 32'h0);
      rd(`LLC_IDX_MULT, 32'hFFFFFFFF, 32'h60);
      chk("oe_n", 32'h1, oe_n);
      chk("mult", 32'h60, mult);
      chk("source", 32'h0, src);
      chk("prescale", 32'h0, pre);
      wr(`LLC_IDX_LOCK, 32'h1, 4'hF, `LLC_RESP_SLVERR);
      rd(`LLC_IDX_LOCK, 32'hFFFFFFFF, 32'h0);
      rd(16'hF007, 32'hFFFFFFFF, 32'h0, `LLC_RESP_SLVERR);
      $display("test reset done");
      // staged settings stay inactive until the run rise
      wr(`LLC_IDX_MULT, 32'h20);
      wr(`LLC_IDX_PRESCALE, 32'h1);
      wr(`LLC_IDX_SOURCE, 32'h1);
      wr(`LLC_IDX_AUX, 32'h7);
      wr(`LLC_IDX_IRQ_MASK, 32'h3);
      chk("mult", 32'h60, mult);
      chk("oe_n", 32'h1, oe_n);
      rd(`LLC_IDX_AUX, 32'hFFFFFFFF, 32'h7);
      wr(`LLC_IDX_RUN, 32'h1);
      @(negedge ref_clk);
      chk("mult", 32'h20, mult);
      chk("prescale", 32'h1, pre);
      chk("source", 32'h1, src);
      chk("oe_n", 32'h0, oe_n);
      repeat (50) @(negedge ref_clk);
      chk("locked", 32'h0, locked);
      chk("pin", 32'h0, pin);
      $display("test staging done");
      // lock with a running master clock, interrupt raised and cleared
      mclk_run <= 1'b1;
      wait_lock();
      repeat (3) @(negedge ref_clk);
      chk("irq", 32'h1, irq);
      rd(`LLC_IDX_IRQ_STAT, 32'h1, 32'h1);
      repeat (2) @(negedge ref_clk);
      chk("irq", 32'h0, irq);
      $display("test lock done");
      // every rate code, each applied by a fresh run rise
      for (int r = 0; r < 4; r++) begin
         wr(`LLC_IDX_RUN, 32'h0);
         repeat (2) @(negedge ref_clk);
         chk("locked", 32'h0, locked);
         chk("pin", 32'h0, pin);
         wr(`LLC_IDX_AUX, {29'h0, r[1:0], 1'b1});
         wr(`LLC_IDX_RUN, 32'h1);
         wait_lock();
         count_rises(n);
         chk("rate", 32'h1, n >= (4 << r) - 1 && n <= (4 << r) + 1);
      end
      $display("test rates done");
      // run written 1 again applies nothing; write without the low byte strobe ignored; enable off tristates
      wr(`LLC_IDX_AUX, 32'h0);
      wr(`LLC_IDX_RUN, 32'h1);
      chk("oe_n", 32'h0, oe_n);
      wr(`LLC_IDX_RUN, 32'h0, 4'hE);
      chk("running", 32'h1, running);
      wr(`LLC_IDX_RUN, 32'h0);
      wr(`LLC_IDX_RUN, 32'h1);
      @(negedge ref_clk);
      chk("oe_n", 32'h1, oe_n);
      $display("test enable done");
      // loss of the master clock drops lock; loss event masked from the interrupt
      wait_lock();
      wr(`LLC_IDX_IRQ_MASK, 32'h1);
      rd(`LLC_IDX_IRQ_STAT, 32'h0, 32'h0);
      mclk_run <= 1'b0;
      repeat (300) @(negedge ref_clk);
      chk("locked", 32'h0, locked);
      chk("irq", 32'h0, irq);
      rd(`LLC_IDX_IRQ_STAT, 32'h2, 32'h2);
      $display("test loss done");
      // a zero multiplier is no valid setting; divide by four then locks again
      wr(`LLC_IDX_MULT, 32'h0);
      wr(`LLC_IDX_PRESCALE, 32'h2);
      wr(`LLC_IDX_RUN, 32'h0);
      wr(`LLC_IDX_RUN, 32'h1);
      mclk_run <= 1'b1;
      repeat (100) @(negedge ref_clk);
      chk("locked", 32'h0, locked);
      chk("prescale", 32'h2, pre);
      wr(`LLC_IDX_MULT, 32'h60);
      wr(`LLC_IDX_RUN, 32'h0);
      wr(`LLC_IDX_RUN, 32'h1);
      wait_lock();
      $display("test config done");
      wrap_up();
   end
endmodule
`default_nettype wire
